// >>> src/le_addr_pkg.sv
// package: widths, encodings and constants for the little-endian address modifier
package le_addr_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int LOW_W = 3;
    localparam int INSTR_BYTES = 4;

    // ------------------------------------------------------------
    // low-bit xor patterns and alignment masks per access width, reset values
    // ------------------------------------------------------------
    localparam logic [2:0] XOR_BYTE = 3'h7;
    localparam logic [2:0] XOR_HALF = 3'h6;
    localparam logic [2:0] XOR_WORD = 3'h4;
    localparam logic [2:0] XOR_DWORD = 3'h0;
    localparam logic [2:0] ALIGN_HALF = 3'h1;
    localparam logic [2:0] ALIGN_WORD = 3'h3;
    localparam logic [2:0] ALIGN_DWORD = 3'h7;
    localparam logic MODE_RESET = 1'b0;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_HALF,
        SIZE_WORD,
        SIZE_DWORD
    } access_size_t;

    typedef enum logic [1:0] {
        KIND_SCALAR,
        KIND_STRING,
        KIND_MULTIPLE
    } access_kind_t;

    typedef struct packed {
        logic valid;
        logic write;
        access_size_t size;
        access_kind_t kind;
        logic [ADDR_W-1:0] effective_address;
    } data_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        access_size_t size;
        logic [ADDR_W-1:0] addr;
    } mem_req_t;

endpackage

// >>> src/le_xor_unit.sv
// leaf: xor of the low effective address bits according to mode and width
`timescale 1ns/1ns
module le_xor_unit (
    input wire logic mode_i,
    input wire le_addr_pkg::access_size_t size_i,
    input wire logic [le_addr_pkg::ADDR_W-1:0] addr_i,
    output logic [le_addr_pkg::ADDR_W-1:0] addr_o
);
    import le_addr_pkg::*;

    logic [2:0] pattern;

    always_comb begin
        case (size_i)
            SIZE_BYTE: pattern = XOR_BYTE;
            SIZE_HALF: pattern = XOR_HALF;
            SIZE_WORD: pattern = XOR_WORD;
            SIZE_DWORD: pattern = XOR_DWORD;
            default: pattern = XOR_DWORD;
        endcase
    end

    // upper bits are wired straight through
    assign addr_o = {addr_i[ADDR_W-1:LOW_W], addr_i[LOW_W-1:0] ^ (mode_i ? pattern : 3'h0)};

endmodule // le_xor_unit

// >>> src/le_address_modifier.sv
// top: little-endian address modification for data accesses and instruction fetch
//
// Overview of operation
// - in little-endian mode, byte access addresses get low three bits inverted.
// - doubleword unchanged, word xor 100, halfword xor 110 in little-endian mode.
// - modified address goes to memory; data moves unswapped, at requested width.
// - xor only valid for aligned scalars; unaligned scalars raise alignment fault in little-endian mode.
// - string and multiple accesses raise alignment interrupt in little-endian mode.
// - instructions are one 32-bit word; address steps one word each.
// - in little-endian mode fetch address is xored with 100.
// - saved, link, branch addresses stay in program (little-endian) address space.
// - mode bit resets to big-endian; only privileged special write changes it.
`timescale 1ns/1ns
module le_address_modifier (
    input wire logic clk_i,
    input wire logic srst_i,
    // mode control
    input wire logic mode_wr_i,
    input wire logic mode_wr_priv_i,
    input wire logic mode_wr_data_i,
    output logic little_endian_mode_bit_o,
    // data side
    input wire le_addr_pkg::data_req_t data_req_i,
    output logic data_ready_o,
    input wire logic mem_ready_i,
    output le_addr_pkg::mem_req_t mem_req_o,
    output logic align_intr_o,
    // data transfer, width honoured, no byte reordering
    input wire logic [63:0] store_data_i,
    output logic [63:0] mem_wdata_o,
    input wire logic [63:0] mem_rdata_i,
    input wire logic mem_rvalid_i,
    output logic [63:0] load_data_o,
    output logic load_valid_o,
    // instruction side
    input wire logic fetch_next_i,
    input wire logic branch_i,
    input wire logic [le_addr_pkg::ADDR_W-1:0] branch_target_i,
    output logic [le_addr_pkg::ADDR_W-1:0] current_instr_address_o,
    output logic [le_addr_pkg::ADDR_W-1:0] fetch_addr_o
);
    import le_addr_pkg::*;

    // ------------------------------------------------------------
    // mode bit
    // ------------------------------------------------------------
    logic little_endian_mode_bit;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            little_endian_mode_bit <= MODE_RESET;
        end else if (mode_wr_i && mode_wr_priv_i) begin
            little_endian_mode_bit <= mode_wr_data_i;
        end
    end

    assign little_endian_mode_bit_o = little_endian_mode_bit;

    // ------------------------------------------------------------
    // data request checking
    // ------------------------------------------------------------
    logic [2:0] align_mask;
    logic misaligned;
    logic nonscalar;
    logic fault;
    logic [ADDR_W-1:0] data_mod_addr;

    always_comb begin
        case (data_req_i.size)
            SIZE_BYTE: align_mask = 3'h0;
            SIZE_HALF: align_mask = ALIGN_HALF;
            SIZE_WORD: align_mask = ALIGN_WORD;
            SIZE_DWORD: align_mask = ALIGN_DWORD;
            default: align_mask = 3'h0;
        endcase
    end

    // unaligned support is optional; in little-endian mode this unit refuses them rather than mangle bytes
    assign misaligned = |(data_req_i.effective_address[2:0] & align_mask);
    assign nonscalar = (data_req_i.kind != KIND_SCALAR);
    assign fault = little_endian_mode_bit && (misaligned || nonscalar);

    le_xor_unit u_data_xor (
        .mode_i(little_endian_mode_bit),
        .size_i(data_req_i.size),
        .addr_i(data_req_i.effective_address),
        .addr_o(data_mod_addr)
    );

    // a faulting request is consumed at once; a good one waits only while an earlier request is stalled at memory
    assign data_ready_o = fault || !mem_req_o.valid || mem_ready_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mem_req_o <= '0;
            mem_wdata_o <= 64'h0;
        end else if (!mem_req_o.valid || mem_ready_i) begin
            mem_req_o.valid <= data_req_i.valid && !fault;
            mem_req_o.write <= data_req_i.write;
            mem_req_o.size <= data_req_i.size;
            mem_req_o.addr <= data_mod_addr;
            mem_wdata_o <= store_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            align_intr_o <= 1'b0;
        end else begin
            align_intr_o <= data_req_i.valid && fault;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            load_data_o <= 64'h0;
            load_valid_o <= 1'b0;
        end else begin
            load_valid_o <= mem_rvalid_i;
            if (mem_rvalid_i) begin
                load_data_o <= mem_rdata_i;
            end
        end
    end

    // ------------------------------------------------------------
    // instruction address
    // ------------------------------------------------------------
    // the program counter lives in the program's own address space, so saved,
    // link and branch addresses need no correction; only the fetch is xored
    logic [ADDR_W-1:0] current_instr_address;
    logic [ADDR_W-1:0] next_fetch_addr;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            current_instr_address <= ADDR_RESET;
        end else if (branch_i) begin
            current_instr_address <= branch_target_i;
        end else if (fetch_next_i) begin
            current_instr_address <= current_instr_address + ADDR_W'(INSTR_BYTES);
        end
    end

    assign current_instr_address_o = current_instr_address;

    le_xor_unit u_fetch_xor (
        .mode_i(little_endian_mode_bit),
        .size_i(SIZE_WORD),
        .addr_i(current_instr_address),
        .addr_o(next_fetch_addr)
    );

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fetch_addr_o <= ADDR_RESET;
        end else begin
            fetch_addr_o <= next_fetch_addr;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_byte_xor_seven: assert property (@(posedge clk_i) disable iff (srst_i)
        (data_req_i.valid && data_ready_o && !fault && data_req_i.size == SIZE_BYTE && little_endian_mode_bit)
        |=> mem_req_o.addr[2:0] == ($past(data_req_i.effective_address[2:0]) ^ 3'h7))
        else $error("byte address not inverted");
    a_word_xor_four: assert property (@(posedge clk_i) disable iff (srst_i)
        (data_req_i.valid && data_ready_o && !fault && data_req_i.size == SIZE_WORD && little_endian_mode_bit)
        |=> mem_req_o.addr[2:0] == ($past(data_req_i.effective_address[2:0]) ^ 3'h4))
        else $error("word address xor wrong");
    a_half_xor_six: assert property (@(posedge clk_i) disable iff (srst_i)
        (data_req_i.valid && data_ready_o && !fault && data_req_i.size == SIZE_HALF && little_endian_mode_bit)
        |=> mem_req_o.addr[2:0] == ($past(data_req_i.effective_address[2:0]) ^ 3'h6))
        else $error("halfword address xor wrong");
    a_big_endian_pass: assert property (@(posedge clk_i) disable iff (srst_i)
        (data_req_i.valid && data_ready_o && !little_endian_mode_bit)
        |=> mem_req_o.valid && mem_req_o.addr == $past(data_req_i.effective_address))
        else $error("big-endian address altered");
    a_upper_bits_kept: assert property (@(posedge clk_i) disable iff (srst_i)
        (data_req_i.valid && data_ready_o && !fault)
        |=> mem_req_o.addr[ADDR_W-1:3] == $past(data_req_i.effective_address[ADDR_W-1:3]))
        else $error("upper address bits altered");
    a_nonscalar_fault: assert property (@(posedge clk_i) disable iff (srst_i)
        (data_req_i.valid && little_endian_mode_bit && data_req_i.kind != KIND_SCALAR)
        |=> align_intr_o && !(mem_req_o.valid && $changed(mem_req_o.addr) && mem_ready_i))
        else $error("string or multiple not trapped");
    a_pc_step_word: assert property (@(posedge clk_i) disable iff (srst_i)
        (fetch_next_i && !branch_i) |=> current_instr_address == $past(current_instr_address) + 32'h4)
        else $error("instruction address step wrong");
    a_fetch_xor_four: assert property (@(posedge clk_i) disable iff (srst_i)
        little_endian_mode_bit ##1 $stable(little_endian_mode_bit)
        |-> fetch_addr_o == ($past(current_instr_address) ^ 32'h4))
        else $error("fetch address xor wrong");
    a_mode_priv_only: assert property (@(posedge clk_i) disable iff (srst_i)
        !(mode_wr_i && mode_wr_priv_i) |=> $stable(little_endian_mode_bit))
        else $error("mode bit changed without privilege");

endmodule // le_address_modifier

// >>> bench/mem_model.sv
// partner model: big-endian memory that answers address-modified requests with stalls
`timescale 1ns/1ns
module mem_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire le_addr_pkg::mem_req_t mem_req_i,
    output logic mem_ready_o,
    output logic [63:0] mem_rdata_o,
    output logic mem_rvalid_o
);
    integer seed = 4711;
    // ----------------------------------------
    // acceptance and read return
    // ----------------------------------------
    // plain always: the seed is updated by the random call as well as initialised
    always @(posedge clk_i) begin
        mem_ready_o <= srst_i ? 1'b0 : ($random(seed) % 3 != 0);
        mem_rvalid_o <= !srst_i && mem_req_i.valid && mem_ready_o && !mem_req_i.write;
        // contents keyed on the address as modified; no byte reordering in memory
        if (srst_i)
            mem_rdata_o <= 64'h0;
        else if (mem_req_i.valid && mem_ready_o)
            mem_rdata_o <= {mem_req_i.addr, ~mem_req_i.addr};
        else
            mem_rdata_o <= ~mem_rdata_o;
    end
endmodule // mem_model

// >>> bench/tb_top.sv
// testbench: random and corner-case checks of the little-endian address modifier
`timescale 1ns/1ns
module tb_top;
    import le_addr_pkg::*;
    logic clk_i, little_endian_mode_bit_o, data_ready_o, mem_ready_i, align_intr_o, mem_rvalid_i, load_valid_o;
    logic srst_i = 1'b1, mode_wr_i = 1'b0, mode_wr_priv_i = 1'b0, mode_wr_data_i = 1'b0, le = 1'b0;
    logic fetch_next_i = 1'b0, branch_i = 1'b0;
    logic [31:0] branch_target_i = 32'h0, current_instr_address_o, fetch_addr_o, ea;
    logic [63:0] store_data_i = 64'h0, mem_wdata_o, mem_rdata_i, load_data_o;
    data_req_t data_req_i = '0;
    mem_req_t mem_req_o;
    access_size_t sz;
    logic [31:0] rdq[$];
    integer seed = 60973;
    int n_fail = 0, cmp_count = 0;
    le_address_modifier uut (.clk_i(clk_i), .srst_i(srst_i), .mode_wr_i(mode_wr_i), .mode_wr_priv_i(mode_wr_priv_i),
        .mode_wr_data_i(mode_wr_data_i), .little_endian_mode_bit_o(little_endian_mode_bit_o),
        .data_req_i(data_req_i), .data_ready_o(data_ready_o), .mem_ready_i(mem_ready_i), .mem_req_o(mem_req_o),
        .align_intr_o(align_intr_o), .store_data_i(store_data_i), .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i), .mem_rvalid_i(mem_rvalid_i), .load_data_o(load_data_o),
        .load_valid_o(load_valid_o), .fetch_next_i(fetch_next_i), .branch_i(branch_i),
        .branch_target_i(branch_target_i), .current_instr_address_o(current_instr_address_o),
        .fetch_addr_o(fetch_addr_o));
    mem_model u_mem (.clk_i(clk_i), .srst_i(srst_i), .mem_req_i(mem_req_o), .mem_ready_o(mem_ready_i),
        .mem_rdata_o(mem_rdata_i), .mem_rvalid_o(mem_rvalid_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // checking and expectations
    // ----------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [2:0] msk(input access_size_t s);
        return 3'((4'h1 << s) - 4'h1);
    endfunction
    function automatic logic [31:0] exp_addr(input access_size_t s, input logic [31:0] a);
        logic [2:0] p;
        p = (s == SIZE_BYTE) ? 3'h7 : (s == SIZE_HALF) ? 3'h6 : (s == SIZE_WORD) ? 3'h4 : 3'h0;
        return le ? {a[31:3], a[2:0] ^ p} : a;
    endfunction
    task automatic wrap_up();
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic set_mode(input logic priv, input logic val);
        @(posedge clk_i);
        mode_wr_i <= 1'b1;
        mode_wr_priv_i <= priv;
        mode_wr_data_i <= val;
        @(posedge clk_i);
        mode_wr_i <= 1'b0;
        mode_wr_data_i <= ~val;
        @(negedge clk_i);
        if (priv)
            le = val;
        check("mode", little_endian_mode_bit_o, le);
    endtask
    task automatic fetch(input logic br, input logic [31:0] tgt);
        logic [31:0] e;
        e = br ? tgt : current_instr_address_o + 32'h4;
        @(posedge clk_i);
        fetch_next_i <= 1'b1;
        branch_i <= br;
        branch_target_i <= tgt;
        @(posedge clk_i);
        fetch_next_i <= 1'b0;
        branch_i <= 1'b0;
        branch_target_i <= ~tgt;
        @(negedge clk_i);
        check("pc", current_instr_address_o, e);
        @(negedge clk_i);
        check("fetch_addr", fetch_addr_o, e ^ (le ? 32'h4 : 32'h0));
    endtask
    task automatic do_req(input logic w, input access_size_t s, input access_kind_t k, input logic [31:0] a);
        logic rdy, f, pend;
        logic [63:0] sd;
        int n;
        f = le && (k != KIND_SCALAR || (a[2:0] & msk(s)) != 3'h0);
        sd = {$random(seed), $random(seed)};
        rdy = 1'b0;
        pend = 1'b0;
        n = 0;
        @(posedge clk_i);
        data_req_i <= '{1'b1, w, s, k, a};
        store_data_i <= sd;
        while (!rdy && n < 50) begin
            @(negedge clk_i);
            rdy = data_ready_o;
            // an earlier request still stalled at the take edge stays on the memory side
            pend = mem_req_o.valid && !mem_ready_i;
            @(posedge clk_i);
            n++;
        end
        data_req_i.valid <= 1'b0;
        data_req_i.effective_address <= ~a;
        @(negedge clk_i);
        check("taken", rdy, 1'b1);
        check("align_intr", align_intr_o, f);
        check("mem_valid", mem_req_o.valid, f ? pend : 1'b1);
        if (!f) begin
            check("mem_addr", mem_req_o.addr, exp_addr(s, a));
            check("mem_size", mem_req_o.size, s);
            check("mem_write", mem_req_o.write, w);
            if (w)
                check("wdata", mem_wdata_o, sd);
            else
                rdq.push_back(exp_addr(s, a));
        end
    endtask
    always @(negedge clk_i) begin
        if (load_valid_o === 1'b1) begin
            if (rdq.size() > 0) begin
                check("load_data", load_data_o, {rdq[0], ~rdq[0]});
                void'(rdq.pop_front());
            end else begin
                check("load_extra", 1'b1, 1'b0);
            end
        end
    end
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        @(negedge clk_i);
        check("rst_mode", little_endian_mode_bit_o, 1'b0);
        check("rst_pc", current_instr_address_o, 32'h0);
        check("rst_fetch", fetch_addr_o, 32'h0);
        check("rst_intr", align_intr_o, 1'b0);
        check("rst_mem_valid", mem_req_o.valid, 1'b0);
        check("rst_load_valid", load_valid_o, 1'b0);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            set_mode(1'b0, ~le);
            set_mode(1'b1, m[0]);
            repeat (3) fetch(1'b0, 32'h0);
            fetch(1'b1, $random(seed) & 32'hffff_fffc);
            for (int i = 0; i < 40; i++) begin
                sz = access_size_t'(2'($random(seed)));
                ea = $random(seed);
                if (i % 4 != 0)
                    ea[2:0] = ea[2:0] & ~msk(sz);
                do_req(ea[3], sz, (i % 9 == 0) ? access_kind_t'(1 + i % 2) : KIND_SCALAR, ea);
            end
            repeat (10) @(posedge clk_i);
            check("reads_done", rdq.size(), 0);
            $display("test mode %0d done", m);
        end
        wrap_up();
    end
endmodule // tb_top
